// File: hw/dac_serial_consts.vh
// constants for the octal dac serial control front end
`ifndef DAC_SERIAL_CONSTS_VH
`define DAC_SERIAL_CONSTS_VH

// word layout
`define WORD_W 16
`define CODE_W 12
`define ADDR_HI 15
`define ADDR_LO 12
`define DATA_HI 11

// target_select codes
`define TS_PAIR_BASE 4'h0
`define TS_CW_ZERO 4'h8
`define TS_CW_ONE 4'h9
`define TS_PRESET 4'hA
`define TS_RESERVED 4'hB

// control_word_zero fields
`define C0_OFF_BIT 4
`define C0_DO_BIT 3
`define C0_REF_HI 2
`define C0_REF_LO 1
`define C0_FMT_BIT 0
`define C0_W 5
`define C0_RESET 5'h00

// control_word_one fields
`define C1_OFF_HI 7
`define C1_OFF_LO 4
`define C1_SP_HI 3
`define C1_SP_LO 0
`define C1_W 8
`define C1_RESET 8'h00

// chain delay in shift clock cycles
`define CHAIN_DELAY 16

`endif

// File: hw/dac_serial_ctrl.v
// serial word capture, register decode and latch logic of the octal dac
// Notes on behaviour
// - frame_sync_n fall starts word, msb first
// - after sixteen bits, load addressed holding register
// - latch_update_n low copies holding into latches
// - serial_out repeats serial_in sixteen clocks later
// - reset clears every latch, holding, preset and control register
// - mode pin low pulse framing, high enable
// - enable framing: early frame rise discards word
// - enable framing: update on closing frame rise
// - pulse framing: capture sixteen bits regardless
// - bits 15..12 address, bits 11..0 data
// - codes 0-7 channels, 8-9 control, 10 preset
// - pair write loads code and complement
// - lower resolutions ignore low data bits
// - force_default_n low outputs preset value
// - control zero bit 4 full shutdown
// - control zero bit 3 enables serial_out
// - control zero bits 2..1 reference select
// - control zero bit 0 code format
// - control one bits 7..4 pair shutdown
// - control one bits 3..0 pair fast settle
`include "dac_serial_consts.vh"

module dac_serial_ctrl #(
   parameter RES = 12,        // 12, 10 or 8 bit variant
   parameter BUF_DEPTH = 2    // words held between capture and decode
) (
   // system
   input wire clk_sys,
   input wire resetn,
   // serial pins
   input wire shift_clock,
   input wire serial_in,
   input wire frame_sync_n,
   input wire latch_update_n,
   input wire force_default_n,
   input wire mode_sel,
   output reg serial_out,
   // channel codes, channel a in the low bits
   output reg [8*`CODE_W-1:0] dac_code,
   // analog controls
   output reg full_shutdown,
   output reg [1:0] ref_select,
   output reg code_format_sel,
   output reg [3:0] pair_shutdown,
   output reg [3:0] pair_fast_settle
);

   localparam AW = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;
   // low code bits below the resolution read as zero; control words unmasked
   localparam [`CODE_W-1:0] RES_MASK = ~((12'h001 << (`CODE_W - RES)) - 12'h001);

   // framing states, one-hot
   localparam [2:0] ST_IDLE = 3'h1;
   localparam [2:0] ST_SHIFT = 3'h2;
   localparam [2:0] ST_HOLD = 3'h4;

   integer i, j;   // one loop index per process, so each has one driver

   // reset release through two flops
   reg [1:0] rst_sync_r;
   wire rst_n;

   always @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
         rst_sync_r <= 2'h0;
      else
         rst_sync_r <= {rst_sync_r[0], 1'b1};
   end
   assign rst_n = rst_sync_r[1];

   // pin synchronisers: bit0 sclk, 1 din, 2 frame, 3 update, 4 pre, 5 mode
   reg [5:0] pin_s1_r;
   reg [5:0] pin_s2_r;
   reg sclk_prev_r;   // previous synced shift clock
   reg frm_prev_r;    // previous synced frame sync

   // active low pins idle high so reset makes no false edge
   always @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pin_s1_r <= 6'h1D;
         pin_s2_r <= 6'h1D;
         sclk_prev_r <= 1'b1;
         frm_prev_r <= 1'b1;
      end
      else
      begin
         pin_s1_r <= {mode_sel, force_default_n, latch_update_n,
                      frame_sync_n, serial_in, shift_clock};
         pin_s2_r <= pin_s1_r;
         sclk_prev_r <= pin_s2_r[0];
         frm_prev_r <= pin_s2_r[2];
      end
   end

   wire din_s = pin_s2_r[1];
   wire frm_s = pin_s2_r[2];
   wire upd_n_s = pin_s2_r[3];
   wire pre_n_s = pin_s2_r[4];
   wire framed_mode = pin_s2_r[5];
   wire sclk_fall = sclk_prev_r & ~pin_s2_r[0];
   wire frm_fall = frm_prev_r & ~frm_s;
   wire frm_rise = ~frm_prev_r & frm_s;

   // capture state
   reg [2:0] state_r;
   reg [2:0] state_nxt;
   reg [`WORD_W-1:0] shift_r;
   reg [4:0] bit_cnt_r;
   reg [`WORD_W-1:0] word_r;     // completed word waiting for the buffer
   reg word_vld_r;
   wire buf_in_ready;
   wire bit_in = (state_r == ST_SHIFT) && sclk_fall;
   wire last_bit = bit_in && (bit_cnt_r == 5'h0F);

   // framing state machine
   always @*
   begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE:
            if (frm_fall)
               state_nxt = ST_SHIFT;
         ST_SHIFT:
            if (last_bit)
               state_nxt = (framed_mode & ~frm_rise) ? ST_HOLD : ST_IDLE;
            else if (framed_mode && frm_rise)
               state_nxt = ST_IDLE;
         ST_HOLD:
            if (frm_rise)
               state_nxt = ST_IDLE;
         default:
            state_nxt = ST_IDLE;
      endcase
   end

   // shift register, bit count and completed word hand-off
   always @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_r <= ST_IDLE;
         shift_r <= 16'h0000;
         bit_cnt_r <= 5'h00;
         word_r <= 16'h0000;
         word_vld_r <= 1'b0;
      end
      else
      begin
         state_r <= state_nxt;
         if (state_r == ST_IDLE)
            bit_cnt_r <= 5'h00;
         if (bit_in)
         begin
            shift_r <= {shift_r[`WORD_W-2:0], din_s};
            bit_cnt_r <= bit_cnt_r + 5'h01;
         end
         // the capture never stalls; a word waits here while the buffer is full
         if (word_vld_r && buf_in_ready)
            word_vld_r <= 1'b0;
         // a frame rise on the last edge itself would never reach the hold
         if (last_bit && (!framed_mode || frm_rise))
         begin
            word_r <= {shift_r[`WORD_W-2:0], din_s};
            word_vld_r <= 1'b1;
         end
         else if (state_r == ST_HOLD && frm_rise)
         begin
            word_r <= shift_r;
            word_vld_r <= 1'b1;
         end
      end
   end

   // two-entry buffer between capture and decode
   reg [`WORD_W-1:0] buf_mem [0:BUF_DEPTH-1];
   reg [AW-1:0] wr_ptr_r;
   reg [AW-1:0] rd_ptr_r;
   reg [AW:0] buf_cnt_r;
   reg dec_busy_r;   // decode takes a settle cycle after each word
   wire buf_out_valid = (buf_cnt_r != 0);
   wire dec_ready = ~dec_busy_r;
   wire push = word_vld_r && buf_in_ready;
   wire pop = buf_out_valid && dec_ready;
   wire [`WORD_W-1:0] pop_word = buf_mem[rd_ptr_r];
   assign buf_in_ready = (buf_cnt_r != BUF_DEPTH);

   // pointers wrap at the depth so any depth works
   always @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wr_ptr_r <= {AW{1'b0}};
         rd_ptr_r <= {AW{1'b0}};
         buf_cnt_r <= {(AW+1){1'b0}};
         dec_busy_r <= 1'b0;
      end
      else
      begin
         dec_busy_r <= pop;
         if (push)
            wr_ptr_r <= (wr_ptr_r == BUF_DEPTH - 1) ? {AW{1'b0}} :
                        wr_ptr_r + {{(AW-1){1'b0}}, 1'b1};
         if (pop)
            rd_ptr_r <= (rd_ptr_r == BUF_DEPTH - 1) ? {AW{1'b0}} :
                        rd_ptr_r + {{(AW-1){1'b0}}, 1'b1};
         if (push && !pop)
            buf_cnt_r <= buf_cnt_r + {{AW{1'b0}}, 1'b1};
         else if (pop && !push)
            buf_cnt_r <= buf_cnt_r - {{AW{1'b0}}, 1'b1};
      end
   end

   // buffer storage, no reset needed since count guards reads
   always @(posedge clk_sys)
   begin
      if (push)
         buf_mem[wr_ptr_r] <= word_r;
   end

   // decode fields of the popped word
   wire [3:0] tsel = pop_word[`ADDR_HI:`ADDR_LO];
   wire [`CODE_W-1:0] pdata = pop_word[`DATA_HI:0] & RES_MASK;
   wire [`CODE_W-1:0] pdata_inv = ~pop_word[`DATA_HI:0] & RES_MASK;

   // holding, latch, preset and control storage
   reg [`CODE_W-1:0] hold_r [0:7];
   reg [`CODE_W-1:0] latch_r [0:7];
   reg [`CODE_W-1:0] preset_r;
   reg [`C0_W-1:0] cw0_r;
   reg [`C1_W-1:0] cw1_r;
   wire [`CODE_W-1:0] fmt_flip = {cw0_r[`C0_FMT_BIT], 11'h000};

   // register writes from decoded words
   always @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         for (i = 0; i < 8; i = i + 1)
            hold_r[i] <= 12'h000;
         preset_r <= 12'h000;
         cw0_r <= `C0_RESET;
         cw1_r <= `C1_RESET;
      end
      else if (pop)
      begin
         case (tsel)
            `TS_CW_ZERO:
               cw0_r <= pop_word[`C0_W-1:0];
            `TS_CW_ONE:
               cw1_r <= pop_word[`C1_W-1:0];
            `TS_PRESET:
               preset_r <= pdata;
            `TS_RESERVED:
               ;
            default:
               if (!tsel[3])
                  hold_r[tsel[2:0]] <= pdata;
               else
               begin
                  hold_r[{tsel[1:0], 1'b0}] <= pdata;
                  hold_r[{tsel[1:0], 1'b1}] <= pdata_inv;
               end
         endcase
      end
   end

   // latch transfer and output drive; preset overrides at the output
   always @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         for (j = 0; j < 8; j = j + 1)
            latch_r[j] <= 12'h000;
         dac_code <= {(8*`CODE_W){1'b0}};
      end
      else
      begin
         for (j = 0; j < 8; j = j + 1)
         begin
            // level sensitive, so a held-low pin tracks every write
            if (!upd_n_s)
               latch_r[j] <= hold_r[j] ^ fmt_flip;
            if (!pre_n_s)
               dac_code[j*`CODE_W +: `CODE_W] <= preset_r;
            else
               dac_code[j*`CODE_W +: `CODE_W] <= latch_r[j];
         end
      end
   end

   // daisy chain delay line, runs on every shift clock fall
   reg [`CHAIN_DELAY-1:0] chain_r;

   always @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         chain_r <= {`CHAIN_DELAY{1'b0}};
         serial_out <= 1'b0;
      end
      else if (sclk_fall)
      begin
         chain_r <= {chain_r[`CHAIN_DELAY-2:0], din_s};
         // held low when chaining is off
         serial_out <= cw0_r[`C0_DO_BIT] & chain_r[`CHAIN_DELAY-1];
      end
   end

   // control outputs registered from the control words
   always @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         full_shutdown <= 1'b0;
         ref_select <= 2'h0;
         code_format_sel <= 1'b0;
         pair_shutdown <= 4'h0;
         pair_fast_settle <= 4'h0;
      end
      else
      begin
         full_shutdown <= cw0_r[`C0_OFF_BIT];
         ref_select <= cw0_r[`C0_REF_HI:`C0_REF_LO];
         code_format_sel <= cw0_r[`C0_FMT_BIT];
         pair_shutdown <= cw1_r[`C1_OFF_HI:`C1_OFF_LO];
         pair_fast_settle <= cw1_r[`C1_SP_HI:`C1_SP_LO];
      end
   end

endmodule

// File: verif/dac_host_model.sv
// serial port master that frames words into the dac front end
module dac_host_model (
   // system
   input wire logic clk_sys,
   // link inputs
   input wire logic mode_sel,
   input wire logic serial_out,
   // link outputs
   output logic shift_clock,
   output logic serial_in,
   output logic frame_sync_n
);
   timeunit 1ns;
   timeprecision 1ps;
   // link rests with clock and frame high
   initial {shift_clock, serial_in, frame_sync_n} = 3'h5;
   // n bits msb first; echo gathers the chained stream
   task automatic xfer(input logic [15:0] w, input int n,
      output logic [15:0] echo);
      echo = 16'h0000;
      if (!mode_sel)
      begin
         shift_clock <= 1'b0;
         repeat (3) @(posedge clk_sys);
      end
      frame_sync_n <= 1'b0;
      repeat (3) @(posedge clk_sys);
      for (int i = 15; i > 15 - n; i--)
      begin
         shift_clock <= 1'b1;
         serial_in <= w[i];
         if (!mode_sel && i == 14)
            frame_sync_n <= 1'b1;
         repeat (5) @(posedge clk_sys);
         shift_clock <= 1'b0;
         repeat (5) @(posedge clk_sys);
         echo = {echo[14:0], serial_out};
      end
      // stale data inverted so it cannot pass for a held bit
      serial_in <= ~serial_in;
      frame_sync_n <= 1'b1;
      shift_clock <= 1'b1;
      repeat (4) @(posedge clk_sys);
   endtask
endmodule

// File: verif/dac_serial_monitor.sv
// assertion checker for the octal dac serial front end
module dac_serial_monitor (
   // system
   input wire logic clk_sys,
   input wire logic resetn,
   // serial pins
   input wire logic shift_clock,
   input wire logic serial_in,
   input wire logic frame_sync_n,
   input wire logic latch_update_n,
   input wire logic force_default_n,
   input wire logic mode_sel,
   input wire logic serial_out,
   // channel codes
   input wire logic [95:0] dac_code,
   // analog controls
   input wire logic full_shutdown,
   input wire logic code_format_sel,
   input wire logic [1:0] ref_select,
   input wire logic [3:0] pair_shutdown,
   input wire logic [3:0] pair_fast_settle
);
   timeunit 1ns;
   timeprecision 1ps;
   logic sc_r, frm_r, ld_r, pr_r; // pins one clock back
   logic [5:0] link_r, any_r; // clocks since last event
   wire link_ev = (sc_r & ~shift_clock) | (~frm_r & frame_sync_n);
   wire any_ev = link_ev | (ld_r ^ latch_update_n) | (pr_r ^ force_default_n);
   wire [3:0] c0_q = {full_shutdown, ref_select, code_format_sel};
   wire [7:0] c1_q = {pair_shutdown, pair_fast_settle};
   // ages saturate so a long quiet spell never wraps back
   always @(posedge clk_sys or negedge resetn)
      if (!resetn)
         {sc_r, frm_r, ld_r, pr_r, link_r, any_r} <= 16'hF000;
      else
      begin
         sc_r <= shift_clock;
         frm_r <= frame_sync_n;
         ld_r <= latch_update_n;
         pr_r <= force_default_n;
         link_r <= link_ev ? 6'h00 : link_r + {5'h00, ~&link_r};
         any_r <= any_ev ? 6'h00 : any_r + {5'h00, ~&any_r};
      end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   sequence pins_idle; (latch_update_n && force_default_n)[*8]; endsequence
   sequence preset_low; (!force_default_n)[*6]; endsequence
   reset_clear_a: assert property ($rose(resetn) |->
      {dac_code, serial_out, c0_q, c1_q} == 109'h0) else $error("not clear");
   chain_step_a: assert property ($changed(serial_out) |->
      link_r <= 8) else $error("chain off step");
   preset_all_a: assert property (preset_low |->
      dac_code == {8{dac_code[11:0]}}) else $error("preset split");
   latch_hold_a: assert property (pins_idle |->
      $stable(dac_code)) else $error("latch leaked");
   ctrl_split_a: assert property ($changed(c0_q) |->
      $stable(c1_q)) else $error("both controls moved");
   ctrl_zero_a: assert property ($changed(c0_q) |->
      link_r <= 16) else $error("control zero moved");
   ctrl_one_a: assert property ($changed(c1_q) |->
      link_r <= 16) else $error("control one moved");
   code_quiet_a: assert property ($changed(dac_code) |->
      any_r <= 16) else $error("code moved");
endmodule
bind dac_serial_ctrl dac_serial_monitor u_dac_serial_monitor (.clk_sys,
   .resetn, .shift_clock, .serial_in, .frame_sync_n, .latch_update_n,
   .force_default_n, .mode_sel, .serial_out, .dac_code, .full_shutdown,
   .code_format_sel, .ref_select, .pair_shutdown, .pair_fast_settle);

// File: verif/tb.sv
// self-checking bench for the octal dac serial front end
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [11:0] res_mask = 12'hFFC; // 10-bit variant
   logic clk_sys = 1'b0, resetn = 1'b0, latch_update_n = 1'b0;
   logic force_default_n = 1'b1, mode_sel = 1'b0;
   wire shift_clock, serial_in, frame_sync_n, serial_out;
   wire full_shutdown, code_format_sel;
   wire [1:0] ref_select;
   wire [3:0] pair_shutdown, pair_fast_settle;
   wire [95:0] dac_code;
   wire [11:0] ctl = {full_shutdown, ref_select, code_format_sel,
      pair_shutdown, pair_fast_settle};
   logic [11:0] hold [8] = '{default: 12'h000}; // holding image
   logic [11:0] lat [8] = '{default: 12'h000}; // latch image
   logic [11:0] pre = 12'h000;
   logic [4:0] c0 = 5'h00;
   logic [7:0] c1 = 8'h00;
   logic [15:0] echo, w1;
   int bad_count = 0, num_checks = 0;
   always #4 clk_sys = ~clk_sys;
   dac_serial_ctrl #(.RES(10)) u_dac_serial_ctrl (.clk_sys, .resetn,
      .shift_clock, .serial_in, .frame_sync_n, .latch_update_n,
      .force_default_n, .mode_sel, .serial_out, .dac_code, .full_shutdown,
      .ref_select, .code_format_sel, .pair_shutdown, .pair_fast_settle);
   dac_host_model u_dac_host_model (.clk_sys, .mode_sel, .serial_out,
      .shift_clock, .serial_in, .frame_sync_n);
   task automatic chk(input logic [95:0] got, input logic [95:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("MISMATCH %0t saw %h want %h", $time, got, exp);
      end
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // channel outputs expected from the image
   function automatic logic [95:0] want();
      for (int k = 0; k < 8; k++)
         want[k*12+:12] = force_default_n ? lat[k] : pre;
   endfunction
   // latch image follows only while the latch pin is low
   task automatic settle;
      for (int k = 0; k < 8 && !latch_update_n; k++)
         lat[k] = hold[k] ^ {c0[0], 11'h000};
      chk(dac_code, want());
      chk(96'(ctl), 96'({c0[4], c0[2:0], c1}));
   endtask
   // one word; the image moves only for a whole word
   task automatic put(input logic [3:0] a, input logic [11:0] d, input int n);
      u_dac_host_model.xfer({a, d}, n, echo);
      if (n == 16)
      begin
         if (a < 4'h8)
            hold[a[2:0]] = d & res_mask;
         if (a >= 4'hC)
         begin
            hold[{a[1:0], 1'b0}] = d & res_mask;
            hold[{a[1:0], 1'b1}] = ~d & res_mask;
         end
         c0 = (a == 4'h8) ? d[4:0] : c0;
         c1 = (a == 4'h9) ? d[7:0] : c1;
         pre = (a == 4'hA) ? d & res_mask : pre;
      end
      repeat (16) @(posedge clk_sys);
      settle;
   endtask
   initial
   begin
      void'($urandom(32'h4666));
      repeat (16) @(posedge clk_sys);
      resetn <= 1'b1;
      repeat (6) @(posedge clk_sys);
      settle;
      put(4'h5, 12'h7FF, 16);
      chk(96'(echo), 96'h0);
      for (int i = 0; i < 16; i++)
         put(4'(i), 12'($urandom), 16);
      // a held latch pin keeps the new code out
      latch_update_n <= 1'b1;
      repeat (8) @(posedge clk_sys);
      put(4'h2, ~hold[2], 16);
      latch_update_n <= 1'b0;
      repeat (8) @(posedge clk_sys);
      settle;
      put(4'hA, 12'hA50, 16);
      force_default_n <= 1'b0;
      repeat (8) @(posedge clk_sys);
      settle;
      force_default_n <= 1'b1;
      mode_sel <= 1'b1;
      repeat (8) @(posedge clk_sys);
      put(4'h3, 12'($urandom), 16);
      put(4'h4, ~hold[4], 10);
      put(4'h8, 12'h009, 16);
      w1 = {1'b0, 15'($urandom)};
      put(w1[15:12], w1[11:0], 16);
      put(4'hC, 12'hFFF, 16);
      chk(96'(echo), 96'(w1));
      tally_and_finish;
   end
   // cut a hung run short
   initial
   begin
      repeat (100000) @(posedge clk_sys);
      bad_count++;
      tally_and_finish;
   end
endmodule
